// >>> pkg/cssp_defs.vh
/*
 * Constants for the clock status and peripheral prescaler select block:
 * register offsets, field positions, reset values and source codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CSSP_DEFS_VH
`define CSSP_DEFS_VH

// Register byte offsets
`define CSSP_OFS_STATUS 12'h034
`define CSSP_OFS_PRESCALE 12'h038

// Reset values
`define CSSP_STATUS_RESET 32'h01000003
`define CSSP_PRESCALE_RESET 32'h00000000

// Status field positions
`define CSSP_INT_USAGE_LSB 24
`define CSSP_EXT_USAGE_LSB 16
`define CSSP_PLL_USAGE_LSB 8
`define CSSP_SWITCH_LSB 0

// System clock source select codes
`define CSSP_SEL_EXT_FAST 3'h2
`define CSSP_SEL_INT_FAST 3'h3

// Switch state codes
`define CSSP_SW_PLL 3'h0
`define CSSP_SW_EXT_FAST 3'h2
`define CSSP_SW_INT_FAST 3'h3
`define CSSP_SW_EXT_SLOW 3'h6
`define CSSP_SW_INT_SLOW 3'h7

// Prescale codes
`define CSSP_DIV1 2'h0
`define CSSP_DIV2 2'h1
`define CSSP_DIV4 2'h2
`define CSSP_DIV8 2'h3

// Prescale field positions, two bits each
`define CSSP_TWO_WIRE0_LSB 0
`define CSSP_TWO_WIRE1_LSB 2
`define CSSP_SERIAL_IF0_LSB 4
`define CSSP_SERIAL_IF1_LSB 6
`define CSSP_BASIC_TIMER0_LSB 12
`define CSSP_BASIC_TIMER1_LSB 14
`define CSSP_MOTOR_TIMER0_LSB 16
`define CSSP_MOTOR_TIMER1_LSB 18
`define CSSP_GP_TIMER0_LSB 20
`define CSSP_GP_TIMER1_LSB 22
`define CSSP_SYNC_ASYNC0_LSB 24
`define CSSP_SYNC_ASYNC1_LSB 26
`define CSSP_ASYNC0_LSB 28
`define CSSP_ASYNC1_LSB 30

// Number of prescaled peripheral clocks
`define CSSP_NUM_PERIPH 14

`endif

// >>> hdl/cssp_prescaler.v
/*
 * One peripheral prescaler: turns the bus/CPU clock into a one-cycle
 * enable at rate 1, 1/2, 1/4 or 1/8.
 * Assumes a shared free running 3-bit phase counter from the parent.
 */
`timescale 1ns/1ps
`include "cssp_defs.vh"

module cssp_prescaler (
    input wire clk_i,
    input wire rst_i,
    input wire [1:0] sel_i,
    input wire [2:0] phase_i,
    output wire clk_en_o
);

    reg [1:0] sel_reg; // Selection actually in use
    reg tick; // Combinational tick for the active selection
    reg en_reg; // Registered enable output

    // Tick at the divided rate, phase aligned to the shared counter
    always @* begin
        case (sel_reg)
            `CSSP_DIV1: tick = 1'h1;
            `CSSP_DIV2: tick = (phase_i[0] == 1'h1);
            `CSSP_DIV4: tick = (phase_i[1:0] == 2'h3);
            default: tick = (phase_i == 3'h7);
        endcase
    end

    // New selection only adopted when all rates agree on a boundary
    always @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg <= `CSSP_DIV1;
            en_reg <= 1'h0;
        end else begin
            if (phase_i == 3'h7) begin
                sel_reg <= sel_i;
            end
            en_reg <= tick;
        end
    end

    assign clk_en_o = en_reg;

endmodule

// >>> hdl/cssp_clock_status.v
/*
 * Clock status and peripheral prescaler select, with a classic
 * Wishbone slave for the two registers and one prescaler per
 * peripheral clock.
 * Assumes the source switching and PLL logic supply usage flags and the
 * current source as same-clock levels. Peripheral clocks are one-cycle
 * enables on clk_i; each peripheral gates its own logic with them.
 */
// Added by the designer: the Wishbone slave port.
// Overview of operation
// - Internal fast oscillator usage: four flag bits
// - External fast oscillator usage: three flag bits
// - PLL output usage: four flag bits
// - System usage bits follow selection codes 3/2
// - Switch state: 00x PLL, 010 ext, 011 int
// - Switch state: 110 slow crystal, 111 slow osc
// - Switch state shows actual source, not request
// - Prescale codes divide by 1, 2, 4, 8
// - Async port prescales at bits 31:28
// - Sync/async port prescales at bits 27:24
// - General timer prescales at bits 23:20
// - Motor timer prescales at bits 19:16
// - Basic timer prescales at bits 15:12
// - Serial interface prescales at bits 7:4
// - Two-wire prescales at bits 3:0
`timescale 1ns/1ps
`include "cssp_defs.vh"

module cssp_clock_status (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire [2:0] sysclk_source_select_i,
    input wire [2:0] sysclk_switch_state_i,
    input wire [2:0] int_fast_osc_usage_i,
    input wire [1:0] ext_fast_osc_usage_i,
    input wire [3:0] pll_out_usage_i,
    output wire [31:0] prescale_sel_o,
    output wire two_wire0_clk_en_o,
    output wire two_wire1_clk_en_o,
    output wire serial_if0_clk_en_o,
    output wire serial_if1_clk_en_o,
    output wire basic_timer0_clk_en_o,
    output wire basic_timer1_clk_en_o,
    output wire motor_timer0_clk_en_o,
    output wire motor_timer1_clk_en_o,
    output wire gp_timer0_clk_en_o,
    output wire gp_timer1_clk_en_o,
    output wire sync_async_port0_clk_en_o,
    output wire sync_async_port1_clk_en_o,
    output wire async_port0_clk_en_o,
    output wire async_port1_clk_en_o
);

    // Writable bits of the prescale register (11:8 reserved)
    localparam [31:0] PRESCALE_MASK = 32'hFFFFF0FF;

    // Registers and their next values
    reg [31:0] prescale_reg; // Prescale selections
    reg [31:0] prescale_next; // Next prescale value
    reg [31:0] status_reg; // Registered status word
    reg [31:0] status_next; // Status word being built
    reg [31:0] rdata_reg; // Read data
    reg [31:0] rdata_next; // Next read data
    reg ack_reg; // Bus acknowledge
    reg [2:0] phase_reg; // Shared divider phase
    reg [3:0] int_usage; // Internal fast oscillator flags
    reg [2:0] ext_usage; // External fast oscillator flags
    reg [2:0] sw_state; // Normalised switch state
    reg [31:0] wmask; // Byte lane write mask

    // Bus qualifier
    wire bus_req; // Live request without pending ack

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;

    // Build the status word from the live source information; bits that
    // no source drives stay zero
    always @* begin
        int_usage = {int_fast_osc_usage_i[2:0],
                     sysclk_source_select_i == `CSSP_SEL_INT_FAST};
        ext_usage = {ext_fast_osc_usage_i[1:0],
                     sysclk_source_select_i == `CSSP_SEL_EXT_FAST};
        // Actual source, with unused codes shown as the PLL
        case (sysclk_switch_state_i)
            `CSSP_SW_EXT_FAST: sw_state = `CSSP_SW_EXT_FAST;
            `CSSP_SW_INT_FAST: sw_state = `CSSP_SW_INT_FAST;
            `CSSP_SW_EXT_SLOW: sw_state = `CSSP_SW_EXT_SLOW;
            `CSSP_SW_INT_SLOW: sw_state = `CSSP_SW_INT_SLOW;
            default: sw_state = {2'h0, sysclk_switch_state_i[0]};
        endcase
        status_next = 32'h00000000;
        status_next[`CSSP_INT_USAGE_LSB +: 4] = int_usage;
        status_next[`CSSP_EXT_USAGE_LSB +: 3] = ext_usage;
        status_next[`CSSP_PLL_USAGE_LSB +: 4] = pll_out_usage_i;
        status_next[`CSSP_SWITCH_LSB +: 3] = sw_state;
    end

    // Write path and read mux
    // Byte lanes pick the written bytes; the reserved nibble is masked on
    // the way in and on the way out, so it can never read back as one
    always @* begin
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        prescale_next = prescale_reg;
        rdata_next = rdata_reg;
        if (bus_req) begin
            rdata_next = 32'h00000000;
            case (wb_adr_i)
                `CSSP_OFS_STATUS: begin
                    // Writes fall away here
                    rdata_next = status_reg;
                end
                `CSSP_OFS_PRESCALE: begin
                    if (wb_we_i) begin
                        prescale_next = ((prescale_reg & ~wmask) | (wb_dat_i & wmask))
                                        & PRESCALE_MASK;
                    end
                    rdata_next = prescale_reg & PRESCALE_MASK;
                end
                default: begin
                    rdata_next = 32'h00000000;
                end
            endcase
        end
    end

    // Prescale register and bus answer; a request is taken only while ack
    // is low, so one strobe held across the ack edge never writes twice
    always @(posedge clk_i) begin
        if (rst_i) begin
            prescale_reg <= `CSSP_PRESCALE_RESET; // All peripherals undivided
            rdata_reg <= 32'h00000000; // Read data cleared
            ack_reg <= 1'h0; // No answer pending
        end else begin
            prescale_reg <= prescale_next;
            rdata_reg <= rdata_next; // Held until the next taken request
            ack_reg <= bus_req; // One-cycle answer
        end
    end

    // Status snapshot; lags the live sources by one cycle so that the
    // read mux sees a settled word
    always @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= `CSSP_STATUS_RESET; // Internal fast oscillator as system clock
        end else begin
            status_reg <= status_next;
        end
    end

    // Shared phase counter; every prescaler counts from the same origin,
    // which lets a new rate be adopted where all rates agree
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= 3'h0; // Phase origin
        end else begin
            phase_reg <= phase_reg + 3'h1; // Wraps every eight cycles
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign prescale_sel_o = prescale_reg;

    // One prescaler per peripheral clock, each fed its own two-bit field.
    // All share the phase counter, so outputs at the same rate pulse in
    // the same cycle and a peripheral pair can exchange data on one edge.
    // A written field reaches its prescaler at once; the prescaler itself
    // defers the switch to the next phase-7 boundary.
    // Two-wire controller 0
    cssp_prescaler u_pre_two_wire0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_TWO_WIRE0_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(two_wire0_clk_en_o)
    );

    // Two-wire controller 1
    cssp_prescaler u_pre_two_wire1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_TWO_WIRE1_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(two_wire1_clk_en_o)
    );

    // Serial peripheral interface 0
    cssp_prescaler u_pre_serial_if0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_SERIAL_IF0_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(serial_if0_clk_en_o)
    );

    // Serial peripheral interface 1
    cssp_prescaler u_pre_serial_if1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_SERIAL_IF1_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(serial_if1_clk_en_o)
    );

    // Basic function timer 0
    cssp_prescaler u_pre_basic_timer0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_BASIC_TIMER0_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(basic_timer0_clk_en_o)
    );

    // Basic function timer 1
    cssp_prescaler u_pre_basic_timer1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_BASIC_TIMER1_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(basic_timer1_clk_en_o)
    );

    // Motor-control timer 0
    cssp_prescaler u_pre_motor_timer0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_MOTOR_TIMER0_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(motor_timer0_clk_en_o)
    );

    // Motor-control timer 1
    cssp_prescaler u_pre_motor_timer1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_MOTOR_TIMER1_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(motor_timer1_clk_en_o)
    );

    // General-purpose timer 0
    cssp_prescaler u_pre_gp_timer0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_GP_TIMER0_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(gp_timer0_clk_en_o)
    );

    // General-purpose timer 1
    cssp_prescaler u_pre_gp_timer1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_GP_TIMER1_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(gp_timer1_clk_en_o)
    );

    // Synchronous/asynchronous serial port 0
    cssp_prescaler u_pre_sync_async_port0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_SYNC_ASYNC0_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(sync_async_port0_clk_en_o)
    );

    // Synchronous/asynchronous serial port 1
    cssp_prescaler u_pre_sync_async_port1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_SYNC_ASYNC1_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(sync_async_port1_clk_en_o)
    );

    // Asynchronous serial port 0
    cssp_prescaler u_pre_async_port0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_ASYNC0_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(async_port0_clk_en_o)
    );

    // Asynchronous serial port 1
    cssp_prescaler u_pre_async_port1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(prescale_reg[`CSSP_ASYNC1_LSB +: 2]),
        .phase_i(phase_reg),
        .clk_en_o(async_port1_clk_en_o)
    );

endmodule

// >>> tb/cssp_clock_status_props.sv
/* Assertions on the ports of the clock status block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module cssp_clock_status_props (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [2:0] sysclk_source_select_i,
    input wire [2:0] sysclk_switch_state_i,
    input wire [31:0] prescale_sel_o,
    input wire two_wire0_clk_en_o,
    input wire async_port1_clk_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since reset, and cycles with two_wire0 held at divide by 8
    logic [3:0] run_cnt;
    logic [3:0] d8_cnt;
    always @(posedge clk_i) begin
        run_cnt <= rst_i ? 4'h0 : run_cnt + {3'h0, run_cnt != 4'hF};
        d8_cnt <= (rst_i || prescale_sel_o[1:0] != 2'h3) ? 4'h0 : d8_cnt + {3'h0, d8_cnt != 4'hF};
    end
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_on_request: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o &&
        prescale_sel_o == 32'h0 && !two_wire0_clk_en_o) else $error("outputs active in reset");
    a_reserved_zero: assert property (prescale_sel_o[11:8] == 4'h0)
        else $error("reserved prescale bits set");
    a_read_back: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 12'h038
        |-> wb_dat_o == prescale_sel_o) else $error("prescale read mismatch");
    a_sys_usage_bits: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 12'h034
        |-> wb_dat_o[24] == ($past(sysclk_source_select_i, 2) == 3'h3) &&
        wb_dat_o[16] == ($past(sysclk_source_select_i, 2) == 3'h2)) else $error("usage bit wrong");
    a_switch_shown: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 12'h034
        && $past(sysclk_switch_state_i, 2) != 3'h4 && $past(sysclk_switch_state_i, 2) != 3'h5
        |-> wb_dat_o[2:0] == $past(sysclk_switch_state_i, 2)) else $error("switch state");
    a_div1_high: assert property (run_cnt > 4'h3 && prescale_sel_o[31:30] == 2'h0 &&
        $past(prescale_sel_o[31:30], 12) == 2'h0 |-> async_port1_clk_en_o) else $error("div1 low");
    a_div8_period: assert property (two_wire0_clk_en_o && d8_cnt == 4'hF |=>
        (!two_wire0_clk_en_o || prescale_sel_o[1:0] != 2'h3)[*7] ##1
        (two_wire0_clk_en_o || prescale_sel_o[1:0] != 2'h3)) else $error("div8 period wrong");
endmodule
bind cssp_clock_status cssp_clock_status_props i_cssp_clock_status_props (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sysclk_source_select_i(sysclk_source_select_i), .sysclk_switch_state_i(sysclk_switch_state_i),
    .prescale_sel_o(prescale_sel_o), .two_wire0_clk_en_o(two_wire0_clk_en_o),
    .async_port1_clk_en_o(async_port1_clk_en_o));

// >>> tb/cssp_periph_model.sv
/* Peripherals fed by the divided clocks: each counts its enable pulses.
   Assumes enables are one-cycle levels on clk_i. */
`timescale 1ns/1ps
module cssp_periph_model (
    input wire clk_i,
    input wire clr_i,
    input wire [13:0] en_i,
    output logic [13:0][7:0] cnt_o
);
    // One tick per enabled cycle, cleared while clr_i is high
    always @(posedge clk_i) begin
        for (int i = 0; i < 14; i++) begin
            cnt_o[i] <= clr_i ? 8'h0 : cnt_o[i] + {7'h0, en_i[i]};
        end
    end
endmodule

// >>> tb/cssp_clock_status_tb_top.sv
/* Bench for the clock status block: register access, status codes and
   pulse counts of every peripheral enable. Assumes design and model. */
`timescale 1ns/1ps
module cssp_clock_status_tb_top;
    typedef struct {logic [31:0] d; logic [3:0] s; logic [31:0] e;} cssp_row_t;
    cssp_row_t rows[5] = '{'{32'hFFFFFFFF, 4'hF, 32'hFFFFF0FF}, '{32'h55555555, 4'hF, 32'h55555055},
        '{32'h12345678, 4'h1, 32'h55555078}, '{32'hE4E41BE4, 4'hC, 32'hE4E45078},
        '{32'h00000000, 4'hF, 32'h00000000}};
    logic [2:0] swc[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, clr = 1;
    logic [11:0] adr = 12'h0;
    logic [3:0] sel = 4'h0, pll = 4'h0;
    logic [31:0] dat = 32'h0, rd;
    logic [2:0] src = 3'h3, sw = 3'h3, ifo = 3'h0;
    logic [1:0] efo = 2'h0;
    wire [31:0] wb_dat_o, prescale_sel_o;
    wire wb_ack_o;
    wire [13:0] en;
    logic [13:0][7:0] cnt;
    int n_mismatch = 0, check_count = 0, cycles = 0;
    cssp_clock_status i_cssp_clock_status (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sysclk_source_select_i(src),
        .sysclk_switch_state_i(sw), .int_fast_osc_usage_i(ifo), .ext_fast_osc_usage_i(efo),
        .pll_out_usage_i(pll), .prescale_sel_o(prescale_sel_o), .two_wire0_clk_en_o(en[0]),
        .two_wire1_clk_en_o(en[1]), .serial_if0_clk_en_o(en[2]), .serial_if1_clk_en_o(en[3]),
        .basic_timer0_clk_en_o(en[4]), .basic_timer1_clk_en_o(en[5]),
        .motor_timer0_clk_en_o(en[6]), .motor_timer1_clk_en_o(en[7]), .gp_timer0_clk_en_o(en[8]),
        .gp_timer1_clk_en_o(en[9]), .sync_async_port0_clk_en_o(en[10]),
        .sync_async_port1_clk_en_o(en[11]), .async_port0_clk_en_o(en[12]),
        .async_port1_clk_en_o(en[13]));
    cssp_periph_model i_cssp_periph_model (.clk_i(clk_i), .clr_i(clr), .en_i(en), .cnt_o(cnt));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One classic cycle; held until ack is sampled high, which should be the second edge
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        chk("ack", 32'h2, n);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // Counts each enable over 64 cycles after the new rate settles
    task automatic pulses(input logic [31:0] p);
        clr <= 1'b1;
        repeat (12) @(posedge clk_i);
        clr <= 1'b0;
        repeat (64) @(posedge clk_i);
        @(negedge clk_i);
        for (int i = 0; i < 14; i++)
            chk("pulses", 32'h40 >> p[(i < 4 ? 2 * i : 2 * i + 4) +: 2], {24'h0, cnt[i]});
        @(posedge clk_i);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 12'h034, 32'h0);
        chk("status", 32'h01000003, rd);
        wb(1'b0, 12'h038, 32'h0);
        chk("prescale", 32'h0, rd);
        foreach (rows[k]) begin
            sel <= rows[k].s;
            wb(1'b1, 12'h038, rows[k].d);
            sel <= 4'hF;
            wb(1'b0, 12'h038, 32'h0);
            chk("prescale", rows[k].e, rd);
            pulses(rows[k].e);
        end
        foreach (swc[j]) begin
            src <= swc[j] ^ 3'h1;
            sw <= swc[j];
            ifo <= j[2:0];
            efo <= j[1:0];
            pll <= j[3:0] + 4'h9;
            repeat (2) @(posedge clk_i);
            wb(1'b1, 12'h034, 32'h0);
            wb(1'b0, 12'h034, 32'h0);
            chk("status", {4'h0, ifo, src == 3'h3, 5'h0, efo, src == 3'h2, 4'h0, pll, 5'h0, sw},
                rd);
        end
        wb(1'b1, 12'h03C, 32'hFFFFFFFF);
        wb(1'b0, 12'h03C, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b1, 12'h038, 32'hFFFFFFFF);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 12'h038, 32'h0);
        chk("prescale", 32'h0, rd);
        conclude();
    end
endmodule
